// >>> dbfcd_map.svh
`ifndef DBFCD_MAP_SVH
`define DBFCD_MAP_SVH

// ----------------------------------------------------------------
// Counter codes and reset values
// ----------------------------------------------------------------
`define DBFCD_CNT_ZERO 3'h0
`define DBFCD_CNT_ONE 3'h1
`define DBFCD_CNT_TWO 3'h2
`define DBFCD_CNT_THREE 3'h3
`define DBFCD_CNT_FOUR 3'h4
`define DBFCD_CNT_RESET 3'h0
`define DBFCD_OUT_RESET 1'h0
`define DBFCD_ZDEC_RESET 1'h1
`define DBFCD_TDEC_RESET 1'h0
`define DBFCD_RUN_RESET 3'h0

// ----------------------------------------------------------------
// Count bit positions
// ----------------------------------------------------------------
`define DBFCD_MSB_POS 2
`define DBFCD_MID_POS 1
`define DBFCD_LSB_POS 0

`endif

// >>> dbfcd_pkg.sv
package dbfcd_pkg;
    typedef logic [2:0] dbfcd_count_t;
endpackage

// >>> dbfcd_divider.sv
`timescale 1ns/1ns
`include "dbfcd_map.svh"
// Functional notes
// RULE_01 - Three flops count zero to four
// RULE_02 - Binary sequence, four returns to zero
// RULE_03 - Top bit high in state four only
// RULE_04 - Middle bit high in states two, three
// RULE_05 - Symmetric output: mid-two rise, zero fall
// RULE_06 - Set term: clock low and state two
// RULE_07 - Reset term active in state zero
// RULE_08 - OR of edge terms clocks output flop
// RULE_09 - Output flop runs off derived edge terms, not counter clock
// RULE_10 - Set forces high, reset low, asynchronously
// RULE_11 - Reset forces count zero, output low
module dbfcd_divider
    import dbfcd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    output logic countMsb,
    output logic countMid,
    output logic countLsb,
    output logic divClkClocked,
    output logic divClkSetReset
);

    // ----------------------------------------------------------------
    // Five-state counter
    // ----------------------------------------------------------------
    dbfcd_count_t count_reg;
    dbfcd_count_t count_next;
    logic isZero_reg;
    logic isTwo_reg;
    logic edgeClk;
    logic setTerm;
    logic rstTerm;

    always_comb begin
        unique case (count_reg)
            `DBFCD_CNT_ZERO: count_next = `DBFCD_CNT_ONE; // RULE_02
            `DBFCD_CNT_ONE: count_next = `DBFCD_CNT_TWO; // RULE_02
            `DBFCD_CNT_TWO: count_next = `DBFCD_CNT_THREE; // RULE_02
            `DBFCD_CNT_THREE: count_next = `DBFCD_CNT_FOUR; // RULE_02
            `DBFCD_CNT_FOUR: count_next = `DBFCD_CNT_ZERO; // RULE_02
            default: count_next = `DBFCD_CNT_ZERO; // Recover from unused codes
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= `DBFCD_CNT_RESET; // RULE_11
        end else begin
            count_reg <= count_next; // RULE_01
        end
    end

    assign countMsb = count_reg[`DBFCD_MSB_POS]; // RULE_03
    assign countMid = count_reg[`DBFCD_MID_POS]; // RULE_04
    assign countLsb = count_reg[`DBFCD_LSB_POS];

    // ----------------------------------------------------------------
    // Registered state decodes
    // ----------------------------------------------------------------
    // Decoding the count directly would glitch on the one-to-two step,
    // where two bits change; one flop per decode keeps the terms clean.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            isZero_reg <= `DBFCD_ZDEC_RESET;
            isTwo_reg <= `DBFCD_TDEC_RESET;
        end else begin
            isZero_reg <= (count_next == `DBFCD_CNT_ZERO);
            isTwo_reg <= (count_next == `DBFCD_CNT_TWO);
        end
    end

    assign setTerm = ~ref_clk & isTwo_reg; // RULE_06
    assign rstTerm = isZero_reg | ~resetn; // RULE_07
    assign edgeClk = setTerm | isZero_reg; // RULE_08

    // ----------------------------------------------------------------
    // Output stage, clocked method
    // ----------------------------------------------------------------
    // Two rising edges per period on edgeClk: mid state two and start
    // of state zero; toggling gives 2.5 input cycles high of five.
    always_ff @(posedge edgeClk or negedge resetn) begin // RULE_09
        if (!resetn) begin
            divClkClocked <= `DBFCD_OUT_RESET; // RULE_11
        end else begin
            divClkClocked <= ~divClkClocked; // RULE_05
        end
    end

    // ----------------------------------------------------------------
    // Output stage, asynchronous set and reset method
    // ----------------------------------------------------------------
    always_ff @(posedge rstTerm or posedge setTerm) begin // RULE_09
        if (rstTerm) begin
            divClkSetReset <= `DBFCD_OUT_RESET; // RULE_10
        end else begin
            divClkSetReset <= 1'h1; // RULE_10
        end
    end

    // ----------------------------------------------------------------
    // Assertion helpers
    // ----------------------------------------------------------------
    // Run lengths of the set-reset output in whole input cycles;
    // a rise lands mid-cycle, so a high run reads three and a low two.
    logic [2:0] highRun_reg;
    logic [2:0] lowRun_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            highRun_reg <= `DBFCD_RUN_RESET;
        end else if (divClkSetReset) begin
            highRun_reg <= 3'(highRun_reg + 3'h1);
        end else begin
            highRun_reg <= `DBFCD_RUN_RESET;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lowRun_reg <= `DBFCD_RUN_RESET;
        end else if (!divClkSetReset) begin
            lowRun_reg <= 3'(lowRun_reg + 3'h1);
        end else begin
            lowRun_reg <= `DBFCD_RUN_RESET;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_count_step: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_01
        (count_reg < `DBFCD_CNT_FOUR) |=> (count_reg == $past(count_reg) + 3'h1))
        else $error("counter did not step by one");

    a_count_legal: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_01
        count_reg <= `DBFCD_CNT_FOUR)
        else $error("counter left the five states");

    a_count_wrap: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_02
        (count_reg == `DBFCD_CNT_FOUR) |=> (count_reg == `DBFCD_CNT_ZERO))
        else $error("counter did not wrap from four to zero");

    a_msb_one_state: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_03
        $rose(countMsb) |=> !countMsb [*4] ##1 countMsb)
        else $error("top count bit not high one state in five");

    a_mid_two_states: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_04
        $rose(countMid) |=> countMid ##1 !countMid [*3] ##1 countMid)
        else $error("middle count bit not high two states in five");

    a_clocked_shape: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_08
        divClkClocked == (count_reg >= `DBFCD_CNT_TWO))
        else $error("clocked divided output out of phase");

    a_setrst_shape: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_06
        divClkSetReset == (count_reg >= `DBFCD_CNT_TWO))
        else $error("set-reset divided output out of phase");

    a_zero_low: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_07
        (count_reg == `DBFCD_CNT_ZERO) |-> !divClkSetReset && !divClkClocked)
        else $error("divided output high in state zero");

    a_half_period: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        $rose(divClkClocked) |-> divClkClocked [*3] ##1 !divClkClocked [*2] ##1 divClkClocked)
        else $error("divided output period not five cycles");

    a_methods_agree: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_10
        divClkClocked == divClkSetReset)
        else $error("output methods disagree");

    a_reset_start: assert property (@(posedge ref_clk) // RULE_11
        $rose(resetn) |-> (count_reg == `DBFCD_CNT_ZERO) && !divClkClocked)
        else $error("reset did not leave state zero and output low");

    // ----------------------------------------------------------------
    // Count bit decodes
    // ----------------------------------------------------------------
    a_next_legal: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_02
        count_next <= `DBFCD_CNT_FOUR)
        else $error("next count outside the five states");

    a_lsb_toggle: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_02
        (count_reg < `DBFCD_CNT_FOUR) |=> (countLsb == !$past(countLsb)))
        else $error("low count bit did not toggle");

    a_msb_decode: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_03
        countMsb == (count_reg == `DBFCD_CNT_FOUR))
        else $error("top count bit not matching state four");

    a_msb_alone: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_03
        countMsb |-> !countMid && !countLsb)
        else $error("top count bit high with other bits");

    a_msb_period: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_03
        $rose(countMsb) |-> ##5 $rose(countMsb))
        else $error("top count bit period not five cycles");

    a_mid_decode: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_04
        countMid == (count_reg == `DBFCD_CNT_TWO || count_reg == `DBFCD_CNT_THREE))
        else $error("middle count bit not matching states two and three");

    a_mid_period: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_04
        $rose(countMid) |-> ##5 $rose(countMid))
        else $error("middle count bit period not five cycles");

    a_lsb_decode: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_01
        countLsb == (count_reg == `DBFCD_CNT_ONE || count_reg == `DBFCD_CNT_THREE))
        else $error("low count bit not matching states one and three");

    // ----------------------------------------------------------------
    // Edge and set-reset terms
    // ----------------------------------------------------------------
    a_zero_decode: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_07
        isZero_reg == (count_reg == `DBFCD_CNT_ZERO))
        else $error("state zero decode out of step");

    a_two_decode: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_06
        isTwo_reg == (count_reg == `DBFCD_CNT_TWO))
        else $error("state two decode out of step");

    a_decode_apart: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_10
        !(isZero_reg && isTwo_reg))
        else $error("set and reset decodes overlap");

    a_reset_term: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_07
        rstTerm == isZero_reg)
        else $error("reset term not following state zero");

    a_edge_term: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_08
        edgeClk |-> (isZero_reg || isTwo_reg))
        else $error("output clock term outside states zero and two");

    // ----------------------------------------------------------------
    // Divided outputs
    // ----------------------------------------------------------------
    a_clk_rise_two: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        $rose(divClkClocked) |-> (count_reg == `DBFCD_CNT_TWO))
        else $error("clocked output rose outside state two");

    a_clk_fall_zero: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        $fell(divClkClocked) |-> (count_reg == `DBFCD_CNT_ZERO))
        else $error("clocked output fell outside state zero");

    a_sr_rise_two: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_06
        $rose(divClkSetReset) |-> (count_reg == `DBFCD_CNT_TWO))
        else $error("set-reset output rose outside state two");

    a_sr_fall_zero: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_07
        $fell(divClkSetReset) |-> (count_reg == `DBFCD_CNT_ZERO))
        else $error("set-reset output fell outside state zero");

    a_out_period: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        $rose(divClkSetReset) |-> ##5 $rose(divClkSetReset))
        else $error("set-reset output period not five cycles");

    a_high_four: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        (count_reg == `DBFCD_CNT_FOUR) |-> divClkClocked && divClkSetReset)
        else $error("divided output low in state four");

    a_low_one: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        (count_reg == `DBFCD_CNT_ONE) |-> !divClkClocked && !divClkSetReset)
        else $error("divided output high in state one");

    a_hold_three: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_09
        (count_reg == `DBFCD_CNT_THREE) |-> $stable(divClkClocked) && $stable(divClkSetReset))
        else $error("divided output moved across state three");

    a_high_run: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        $fell(divClkSetReset) |-> (highRun_reg == 3'h3))
        else $error("divided output high run not three samples");

    a_low_run: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        $rose(divClkSetReset) |-> (lowRun_reg == 3'h2))
        else $error("divided output low run not two samples");

    a_run_bound: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
        (highRun_reg <= 3'h3) && (lowRun_reg <= 3'h2))
        else $error("divided output run too long");

    a_reset_decodes: assert property (@(posedge ref_clk) // RULE_11
        $rose(resetn) |-> isZero_reg && !isTwo_reg)
        else $error("reset did not leave decodes in state zero");

    a_reset_setreset: assert property (@(posedge ref_clk) // RULE_11
        $rose(resetn) |-> !divClkSetReset)
        else $error("reset did not leave set-reset output low");

    c_wrap: cover property (@(posedge ref_clk) disable iff (!resetn)
        count_reg == `DBFCD_CNT_FOUR ##1 count_reg == `DBFCD_CNT_ZERO);

    c_out_rise: cover property (@(posedge ref_clk) disable iff (!resetn)
        $rose(divClkSetReset));

    c_out_fall: cover property (@(posedge ref_clk) disable iff (!resetn)
        $fell(divClkClocked));

    c_reset_release: cover property (@(posedge ref_clk)
        $rose(resetn));

    c_sr_fall: cover property (@(posedge ref_clk) disable iff (!resetn)
        $fell(divClkSetReset));

endmodule

// >>> dbfcd_sink.sv
`timescale 1ns/1ns
// ----------------------------------------
// Downstream load timing the divided clock
// ----------------------------------------
module dbfcd_sink (
    input wire logic divClk,
    output int highNs,
    output int lowNs
);
    time riseAt = 0;
    time fallAt = 0;
    initial highNs = 0;
    initial lowNs = 0;
    always @(posedge divClk) begin
        lowNs = int'($time - fallAt);
        riseAt = $time;
    end
    always @(negedge divClk) begin
        highNs = int'($time - riseAt);
        fallAt = $time;
    end
endmodule

// >>> test_divide_by_five_clock_divider.sv
`timescale 1ns/1ns
`include "dbfcd_map.svh"
module test_divide_by_five_clock_divider;
    import dbfcd_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic countMsb, countMid, countLsb, divClkClocked, divClkSetReset;
    dbfcd_count_t cnt;
    int highNs, lowNs;
    int n_errors = 0;
    int num_checks = 0;
    always #10 ref_clk = ~ref_clk;
    assign cnt = {countMsb, countMid, countLsb};
    dbfcd_divider dbfcd_divider_inst (.ref_clk(ref_clk), .resetn(resetn),
        .countMsb(countMsb), .countMid(countMid), .countLsb(countLsb),
        .divClkClocked(divClkClocked), .divClkSetReset(divClkSetReset));
    dbfcd_sink dbfcd_sink_inst (.divClk(divClkClocked), .highNs(highNs), .lowNs(lowNs));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_state();
        check(8'(cnt), 8'(`DBFCD_CNT_RESET), "count in reset");
        check(8'(divClkClocked), 8'(`DBFCD_OUT_RESET), "clocked out in reset");
        check(8'(divClkSetReset), 8'(`DBFCD_OUT_RESET), "setreset out in reset");
    endtask
    task automatic test_sequence_and_outputs();
        int s;
        for (int k = 1; k <= 15; k++) begin
            s = k % 5;
            @(posedge ref_clk);
            #2;
            check(8'(cnt), 8'(s), "count step");
            check(8'(countMsb), 8'(s == 4), "msb decode");
            check(8'(countMid), 8'(s == 2 || s == 3), "mid decode");
            check(8'(divClkClocked), 8'(s == 3 || s == 4), "clocked after rise");
            check(8'(divClkSetReset), 8'(s == 3 || s == 4), "setreset after rise");
            @(negedge ref_clk);
            #2;
            check(8'(divClkClocked), 8'(s >= 2), "clocked mid state");
            check(8'(divClkSetReset), 8'(s >= 2), "setreset mid state");
        end
        check(8'(highNs), 8'h32, "high time");
        check(8'(lowNs), 8'h32, "low time");
    endtask
    task automatic test_midrun_reset();
        int guard;
        guard = 0;
        while (cnt !== `DBFCD_CNT_FOUR && guard < 10) begin
            @(posedge ref_clk);
            #1;
            guard++;
        end
        resetn = 1'b0;
        #1;
        check(8'(cnt), 8'(`DBFCD_CNT_ZERO), "count async reset");
        check(8'(divClkClocked), 8'h00, "clocked async reset");
        check(8'(divClkSetReset), 8'h00, "setreset async reset");
        @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        @(posedge ref_clk);
        #2;
        check(8'(cnt), 8'(`DBFCD_CNT_ONE), "first step after reset");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        test_reset_state();
        #1;
        resetn = 1'b1;
        test_sequence_and_outputs();
        test_midrun_reset();
        summarize();
    end
    initial begin
        #5000;
        n_errors++;
        summarize();
    end
endmodule
